// File: hdl/srf_pkg.sv
// shared constants for the source route parser and local command response framer
package srf_pkg;
	localparam logic [7:0] START_BYTE = 8'h7E;
	localparam logic [7:0] TYPE_ROUTE = 8'h21;
	localparam logic [7:0] TYPE_LCMD = 8'h08;
	localparam logic [7:0] TYPE_LCMD_Q = 8'h09;
	localparam logic [7:0] TYPE_LRESP = 8'h88;
	localparam logic [7:0] CSUM_BASE = 8'hFF;
	localparam logic [15:0] OFS_TYPE = 16'h0003;
	localparam logic [15:0] OFS_ID = 16'h0004;
	localparam logic [15:0] OFS_DEST64 = 16'h0005;
	localparam logic [15:0] OFS_DEST16 = 16'h000D;
	localparam logic [15:0] OFS_OPT = 16'h000F;
	localparam logic [15:0] OFS_HOPS = 16'h0010;
	localparam logic [15:0] OFS_ADDR = 16'h0011;
	localparam logic [15:0] OFS_CMD = 16'h0005;
	localparam logic [15:0] OFS_STATUS = 16'h0007;
	localparam logic [15:0] OFS_DATA = 16'h0008;
	localparam logic [7:0] MAX_HOPS = 8'h1E;
	localparam logic [15:0] ROUTE_FIXED_LEN = 16'h000E;
	localparam logic [15:0] RESP_FIXED_LEN = 16'h0005;
	localparam int DATA_MAX = 16;
	localparam int ROUTE_ENTRIES = 8;
	localparam logic [1:0] STAT_OK = 2'h0;
	localparam logic [1:0] STAT_ERROR = 2'h1;
	localparam logic [1:0] STAT_BAD_CMD = 2'h2;
	localparam logic [1:0] STAT_BAD_PARAM = 2'h3;
	localparam logic [15:0] NODE_DISC_CMD = 16'h4E44;
	typedef enum logic [2:0] {
		SRF_RX_IDLE = 3'b000,
		SRF_RX_LEN = 3'b001,
		SRF_RX_BODY = 3'b011,
		SRF_RX_CSUM = 3'b010
	} srf_rx_state_t;
	typedef enum logic [2:0] {
		SRF_TX_IDLE = 3'b000,
		SRF_TX_HEAD = 3'b001,
		SRF_TX_BODY = 3'b011,
		SRF_TX_CSUM = 3'b010
	} srf_tx_state_t;
endpackage

// File: hdl/srf_route_table.sv
// source route table storage
`timescale 1ns/10ps
module srf_route_table (
	// clock
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// write side
	input wire logic wr_en,
	input wire logic [2:0] wr_slot,
	input wire logic [63:0] wr_dest64,
	input wire logic [15:0] wr_dest16,
	input wire logic [4:0] wr_hops,
	input wire logic [479:0] wr_hop_list,
	// read side
	input wire logic [2:0] rd_slot,
	output logic rd_valid,
	output logic [63:0] rd_dest64,
	output logic [15:0] rd_dest16,
	output logic [4:0] rd_hops,
	output logic [479:0] rd_hop_list
);
	logic [564:0] mem [0:srf_pkg::ROUTE_ENTRIES-1];
	logic [srf_pkg::ROUTE_ENTRIES-1:0] valid_reg, valid_next;
	logic [565:0] rd_reg, rd_next;

	always_comb begin
		valid_next = valid_reg;
		if (wr_en)
			valid_next[wr_slot] = 1'b1;
		rd_next = {valid_reg[rd_slot], mem[rd_slot]};
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			valid_reg <= '0;
			rd_reg <= '0;
		end else if (ce) begin
			valid_reg <= valid_next;
			rd_reg <= rd_next;
			if (wr_en)
				mem[wr_slot] <= {wr_dest64, wr_dest16, wr_hops, wr_hop_list};
		end
	end

	assign {rd_valid, rd_dest64, rd_dest16, rd_hops, rd_hop_list} = rd_reg;
endmodule

// File: hdl/srf_resp_tx.sv
// local command response frame builder
`timescale 1ns/10ps
module srf_resp_tx (
	// clock
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// request
	input wire logic start,
	input wire logic [7:0] frame_id,
	input wire logic [15:0] cmd,
	input wire logic [1:0] status,
	input wire logic [4:0] data_len,
	input wire logic [127:0] data,
	output logic busy,
	// byte stream out
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready
);
	srf_pkg::srf_tx_state_t state_reg, state_next;
	logic [15:0] idx_reg, idx_next;
	logic [15:0] len_reg, len_next;
	logic [7:0] sum_reg, sum_next;
	logic [7:0] byte_c;
	logic [7:0] id_reg, id_next;
	logic [15:0] cmd_reg, cmd_next;
	logic [1:0] st_reg, st_next;
	logic [127:0] dat_reg, dat_next;
	logic [15:0] di;

	always_comb begin
		di = idx_reg - srf_pkg::OFS_DATA;
		case (idx_reg)
			16'h0000: byte_c = srf_pkg::START_BYTE;
			16'h0001: byte_c = len_reg[15:8];
			16'h0002: byte_c = len_reg[7:0];
			srf_pkg::OFS_TYPE: byte_c = srf_pkg::TYPE_LRESP;
			srf_pkg::OFS_ID: byte_c = id_reg;
			srf_pkg::OFS_CMD: byte_c = cmd_reg[15:8];
			16'h0006: byte_c = cmd_reg[7:0];
			srf_pkg::OFS_STATUS: byte_c = {6'h00, st_reg};
			default: byte_c = dat_reg[127 - 8*di[3:0] -: 8];
		endcase
	end

	always_comb begin
		state_next = state_reg;
		idx_next = idx_reg;
		len_next = len_reg;
		sum_next = sum_reg;
		id_next = id_reg;
		cmd_next = cmd_reg;
		st_next = st_reg;
		dat_next = dat_reg;
		case (state_reg)
			srf_pkg::SRF_TX_IDLE: begin
				if (start) begin
					id_next = frame_id;
					cmd_next = cmd;
					st_next = status;
					dat_next = data;
					len_next = srf_pkg::RESP_FIXED_LEN + {11'h000, data_len};
					idx_next = '0;
					sum_next = '0;
					state_next = srf_pkg::SRF_TX_HEAD;
				end
			end
			srf_pkg::SRF_TX_HEAD: begin
				if (tx_ready) begin
					idx_next = idx_reg + 16'h0001;
					if (idx_reg == 16'h0002)
						state_next = srf_pkg::SRF_TX_BODY;
				end
			end
			srf_pkg::SRF_TX_BODY: begin
				if (tx_ready) begin
					sum_next = sum_reg + byte_c;
					idx_next = idx_reg + 16'h0001;
					if (idx_reg == len_reg + 16'h0002)
						state_next = srf_pkg::SRF_TX_CSUM;
				end
			end
			srf_pkg::SRF_TX_CSUM: begin
				if (tx_ready)
					state_next = srf_pkg::SRF_TX_IDLE;
			end
			default: state_next = srf_pkg::SRF_TX_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= srf_pkg::SRF_TX_IDLE;
			idx_reg <= '0;
			len_reg <= '0;
			sum_reg <= '0;
			id_reg <= '0;
			cmd_reg <= '0;
			st_reg <= '0;
			dat_reg <= '0;
		end else if (ce) begin
			state_reg <= state_next;
			idx_reg <= idx_next;
			len_reg <= len_next;
			sum_reg <= sum_next;
			id_reg <= id_next;
			cmd_reg <= cmd_next;
			st_reg <= st_next;
			dat_reg <= dat_next;
		end
	end

	assign busy = state_reg != srf_pkg::SRF_TX_IDLE;
	assign tx_valid = busy;
	assign tx_data = (state_reg == srf_pkg::SRF_TX_CSUM) ? srf_pkg::CSUM_BASE - sum_reg : byte_c;
endmodule

// File: hdl/srf_frame_top.sv
// frame parser for source route requests and local command response path
`timescale 1ns/10ps
module srf_frame_top (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// incoming byte stream from the host
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	// local command request seen, for the command engine
	output logic lcmd_valid,
	output logic [7:0] lcmd_id,
	output logic [15:0] lcmd_cmd,
	output logic lcmd_query,
	// result from the command engine
	input wire logic res_valid,
	input wire logic [1:0] res_status,
	input wire logic [4:0] res_data_len,
	input wire logic [127:0] res_data,
	input wire logic res_more,
	output logic res_ready,
	// response byte stream to the host
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	// route table lookup and status
	input wire logic [2:0] rt_rd_slot,
	output logic rt_rd_valid,
	output logic [63:0] rt_rd_dest64,
	output logic [15:0] rt_rd_dest16,
	output logic [4:0] rt_rd_hops,
	output logic [479:0] rt_rd_hop_list,
	output logic route_added,
	output logic frame_dropped
);
	srf_pkg::srf_rx_state_t state_reg, state_next;
	logic [15:0] len_reg, len_next;
	logic [15:0] idx_reg, idx_next;
	logic [7:0] sum_reg, sum_next;
	logic [7:0] type_reg, type_next;
	logic [7:0] id_reg, id_next;
	logic [63:0] d64_reg, d64_next;
	logic [15:0] d16_reg, d16_next;
	logic [7:0] hops_reg, hops_next;
	logic [479:0] hl_reg, hl_next;
	logic [15:0] cmd_reg, cmd_next;
	logic [2:0] slot_reg, slot_next;
	logic wr_en_reg, wr_en_next;
	logic lv_reg, lv_next;
	logic lq_reg, lq_next;
	logic drop_reg, drop_next;
	logic pend_reg, pend_next;
	logic [7:0] tx_id_reg, tx_id_next;
	logic [15:0] tx_cmd_reg, tx_cmd_next;
	logic [7:0] rxd_s1, rxd_s2;
	logic rxv_s1, rxv_s2;
	logic [7:0] b;
	logic [7:0] sum_add;
	logic [15:0] hi;
	logic route_ok;
	logic tx_busy;
	logic tx_start;
	logic [7:0] txd_w;
	logic txv_w;
	logic [7:0] txd_reg;
	logic txv_reg;

	// rx_data and rx_valid pass two flip-flops
	always_ff @(posedge clk) begin
		if (srst) begin
			rxd_s1 <= '0;
			rxd_s2 <= '0;
			rxv_s1 <= 1'b0;
			rxv_s2 <= 1'b0;
		end else if (ce) begin
			rxd_s1 <= rx_data;
			rxd_s2 <= rxd_s1;
			rxv_s1 <= rx_valid;
			rxv_s2 <= rxv_s1;
		end
	end

	assign b = rxd_s2;

	always_comb begin
		sum_add = sum_reg + b;
		hi = idx_reg - srf_pkg::OFS_ADDR;
		route_ok = (hops_reg != 8'h00) && (hops_reg <= srf_pkg::MAX_HOPS)
			&& (len_reg == srf_pkg::ROUTE_FIXED_LEN + {7'h00, hops_reg, 1'b0});
		state_next = state_reg;
		len_next = len_reg;
		idx_next = idx_reg;
		sum_next = sum_reg;
		type_next = type_reg;
		id_next = id_reg;
		d64_next = d64_reg;
		d16_next = d16_reg;
		hops_next = hops_reg;
		hl_next = hl_reg;
		cmd_next = cmd_reg;
		slot_next = slot_reg;
		wr_en_next = 1'b0;
		lv_next = 1'b0;
		lq_next = lq_reg;
		drop_next = 1'b0;
		if (rxv_s2) begin
			case (state_reg)
				srf_pkg::SRF_RX_IDLE: begin
					if (b == srf_pkg::START_BYTE) begin
						state_next = srf_pkg::SRF_RX_LEN;
						idx_next = 16'h0001;
						sum_next = '0;
						hl_next = '0;
					end
				end
				srf_pkg::SRF_RX_LEN: begin
					idx_next = idx_reg + 16'h0001;
					if (idx_reg == 16'h0001)
						len_next[15:8] = b;
					else begin
						len_next[7:0] = b;
						state_next = ({len_reg[15:8], b} == 16'h0000) ? srf_pkg::SRF_RX_IDLE
							: srf_pkg::SRF_RX_BODY;
					end
				end
				srf_pkg::SRF_RX_BODY: begin
					sum_next = sum_add;
					idx_next = idx_reg + 16'h0001;
					if (idx_reg == srf_pkg::OFS_TYPE)
						type_next = b;
					if (idx_reg == srf_pkg::OFS_ID)
						id_next = b;
					if (idx_reg >= srf_pkg::OFS_DEST64 && idx_reg < srf_pkg::OFS_DEST16)
						d64_next = {d64_reg[55:0], b};
					if (idx_reg >= srf_pkg::OFS_DEST16 && idx_reg < srf_pkg::OFS_OPT)
						d16_next = {d16_reg[7:0], b};
					if (idx_reg == srf_pkg::OFS_CMD || idx_reg == 16'h0006)
						cmd_next = {cmd_reg[7:0], b};
					if (idx_reg == srf_pkg::OFS_HOPS)
						hops_next = b;
					if (idx_reg >= srf_pkg::OFS_ADDR && hi < 16'd60)
						hl_next[479 - 8*hi[5:0] -: 8] = b;
					if (idx_reg == len_reg + 16'h0002)
						state_next = srf_pkg::SRF_RX_CSUM;
				end
				srf_pkg::SRF_RX_CSUM: begin
					state_next = srf_pkg::SRF_RX_IDLE;
					if (b != srf_pkg::CSUM_BASE - sum_reg)
						drop_next = 1'b1;
					else if (type_reg == srf_pkg::TYPE_ROUTE) begin
						if (route_ok) begin
							wr_en_next = 1'b1;
							slot_next = slot_reg + 3'h1;
						end else
							drop_next = 1'b1;
					end else if (type_reg == srf_pkg::TYPE_LCMD
						|| type_reg == srf_pkg::TYPE_LCMD_Q) begin
						lv_next = 1'b1;
						lq_next = (len_reg == 16'h0004);
					end
				end
				default: state_next = srf_pkg::SRF_RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= srf_pkg::SRF_RX_IDLE;
			len_reg <= '0;
			idx_reg <= '0;
			sum_reg <= '0;
			type_reg <= '0;
			id_reg <= '0;
			d64_reg <= '0;
			d16_reg <= '0;
			hops_reg <= '0;
			hl_reg <= '0;
			cmd_reg <= '0;
			slot_reg <= '0;
			wr_en_reg <= 1'b0;
			lv_reg <= 1'b0;
			lq_reg <= 1'b0;
			drop_reg <= 1'b0;
		end else if (ce) begin
			state_reg <= state_next;
			len_reg <= len_next;
			idx_reg <= idx_next;
			sum_reg <= sum_next;
			type_reg <= type_next;
			id_reg <= id_next;
			d64_reg <= d64_next;
			d16_reg <= d16_next;
			hops_reg <= hops_next;
			hl_reg <= hl_next;
			cmd_reg <= cmd_next;
			slot_reg <= slot_next;
			wr_en_reg <= wr_en_next;
			lv_reg <= lv_next;
			lq_reg <= lq_next;
			drop_reg <= drop_next;
		end
	end

	// route entry store; route path never touches the response framer
	srf_route_table u_table (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.wr_en(wr_en_reg),
		.wr_slot(slot_reg - 3'h1),
		.wr_dest64(d64_reg),
		.wr_dest16(d16_reg),
		.wr_hops(hops_reg[4:0]),
		.wr_hop_list(hl_reg),
		.rd_slot(rt_rd_slot),
		.rd_valid(rt_rd_valid),
		.rd_dest64(rt_rd_dest64),
		.rd_dest16(rt_rd_dest16),
		.rd_hops(rt_rd_hops),
		.rd_hop_list(rt_rd_hop_list)
	);

	// pending response context; results may repeat while more are due
	always_comb begin
		pend_next = pend_reg;
		tx_id_next = tx_id_reg;
		tx_cmd_next = tx_cmd_reg;
		if (lv_reg && id_reg != 8'h00) begin
			pend_next = 1'b1;
			tx_id_next = id_reg;
			tx_cmd_next = cmd_reg;
		end else if (tx_start && !res_more)
			pend_next = 1'b0;
	end

	assign tx_start = pend_reg && res_valid && !tx_busy;

	always_ff @(posedge clk) begin
		if (srst) begin
			pend_reg <= 1'b0;
			tx_id_reg <= '0;
			tx_cmd_reg <= '0;
			txd_reg <= '0;
			txv_reg <= 1'b0;
		end else if (ce) begin
			pend_reg <= pend_next;
			tx_id_reg <= tx_id_next;
			tx_cmd_reg <= tx_cmd_next;
			txd_reg <= txd_w;
			txv_reg <= txv_w && tx_ready;
		end
	end

	srf_resp_tx u_tx (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.start(tx_start),
		.frame_id(tx_id_reg),
		.cmd(tx_cmd_reg),
		.status(res_status),
		.data_len(lq_reg ? res_data_len : 5'h00),
		.data(res_data),
		.busy(tx_busy),
		.tx_data(txd_w),
		.tx_valid(txv_w),
		.tx_ready(tx_ready)
	);

	assign res_ready = tx_start;
	assign tx_data = txd_reg;
	assign tx_valid = txv_reg;
	assign lcmd_valid = lv_reg;
	assign lcmd_id = id_reg;
	assign lcmd_cmd = cmd_reg;
	assign lcmd_query = lq_reg;
	assign route_added = wr_en_reg;
	assign frame_dropped = drop_reg;
endmodule

// File: tb/srf_frame_chk.sv
// assertions on the frame top ports
`timescale 1ns/10ps
module srf_frame_chk (
	// clock
	input wire logic clk,
	input wire logic srst,
	// watched
	input wire logic [7:0] lcmd_id,
	input wire logic [15:0] lcmd_cmd,
	input wire logic res_valid,
	input wire logic res_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic route_added,
	input wire logic frame_dropped
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	sequence s_head;
		tx_data == 8'h7E ##1 tx_data == 8'h00 ##2 tx_data == 8'h88;
	endsequence
	sequence s_echo;
		tx_data == lcmd_id ##1 tx_data == lcmd_cmd[15:8] ##1 tx_data == lcmd_cmd[7:0];
	endsequence
	a_resp_head: assert property ($rose(tx_valid) |-> s_head)
		else $error("response header wrong");
	a_resp_echo: assert property ($rose(tx_valid) |-> ##4 s_echo)
		else $error("response id or command wrong");
	a_resp_cause: assert property ($rose(tx_valid) |-> $past(res_ready, 2))
		else $error("response without taken result");
	a_nonzero_id: assert property (tx_valid |-> lcmd_id != 8'h00)
		else $error("response for zero id");
	a_ready_valid: assert property (res_ready |-> res_valid)
		else $error("result taken while not offered");
	a_add_drop: assert property (route_added |-> !frame_dropped)
		else $error("route added and dropped together");
	a_drop_pulse: assert property (frame_dropped |=> !frame_dropped)
		else $error("drop pulse too long");
	a_add_pulse: assert property (route_added |=> !route_added)
		else $error("add pulse too long");
endmodule
bind srf_frame_top srf_frame_chk u_chk (.clk(clk), .srst(srst), .lcmd_id(lcmd_id),
	.lcmd_cmd(lcmd_cmd), .res_valid(res_valid), .res_ready(res_ready), .tx_data(tx_data),
	.tx_valid(tx_valid), .route_added(route_added), .frame_dropped(frame_dropped));

// File: tb/srf_host_model.sv
// host model: frames bytes toward the device and gathers its replies
`timescale 1ns/10ps
module srf_host_model (
	// clock
	input wire logic clk,
	// toward the device
	output logic [7:0] rx_data,
	output logic rx_valid,
	// from the device
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready
);
	logic [7:0] rq[$];
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b1;
	end
	always @(negedge clk) begin
		if (tx_valid && tx_ready) begin
			rq.push_back(tx_data);
		end
	end
	// bad flips checksum bits
	task automatic send(input logic [7:0] body[$], input logic [7:0] bad);
		logic [7:0] f[$];
		logic [7:0] sum;
		sum = 8'h00;
		foreach (body[i]) begin
			sum += body[i];
		end
		f = {8'h7E, 8'h00, 8'(body.size()), body, (8'hFF - sum) ^ bad};
		foreach (f[i]) begin
			@(negedge clk);
			rx_data = f[i];
			rx_valid = 1'b1;
		end
		@(negedge clk);
		rx_valid = 1'b0;
		rx_data = ~rx_data;
	endtask
endmodule

// File: tb/srf_frame_top_tb.sv
// self-checking bench for the frame top
`timescale 1ns/10ps
module srf_frame_top_tb;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] rx_data, tx_data, lcmd_id;
	logic rx_valid, tx_valid, tx_ready, lcmd_valid, lcmd_query, res_ready, rt_rd_valid;
	logic route_added, frame_dropped, res_valid = 1'b0, res_more = 1'b0;
	logic [15:0] lcmd_cmd, rt_rd_dest16;
	logic [1:0] res_status = 2'h0;
	logic [4:0] res_data_len = 5'h0, rt_rd_hops;
	logic [127:0] res_data = 128'h0;
	logic [2:0] rt_rd_slot = 3'h0;
	logic [63:0] rt_rd_dest64;
	logic [479:0] rt_rd_hop_list;
	int bad_count = 0, num_checks = 0, adds = 0, drops = 0, slot = 0;
	always #50 clk = ~clk;
	always @(negedge clk) begin
		adds += route_added;
		drops += frame_dropped;
	end
	srf_frame_top dut (.clk(clk), .srst(srst), .ce(1'b1), .rx_data(rx_data),
		.rx_valid(rx_valid), .lcmd_valid(lcmd_valid), .lcmd_id(lcmd_id), .lcmd_cmd(lcmd_cmd),
		.lcmd_query(lcmd_query), .res_valid(res_valid), .res_status(res_status),
		.res_data_len(res_data_len), .res_data(res_data), .res_more(res_more),
		.res_ready(res_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.rt_rd_slot(rt_rd_slot), .rt_rd_valid(rt_rd_valid), .rt_rd_dest64(rt_rd_dest64),
		.rt_rd_dest16(rt_rd_dest16), .rt_rd_hops(rt_rd_hops), .rt_rd_hop_list(rt_rd_hop_list),
		.route_added(route_added), .frame_dropped(frame_dropped));
	srf_host_model host (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim();
		if (bad_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic route(input int n, input logic [7:0] hops, input logic [7:0] bad, input bit ok);
		logic [7:0] b[$];
		logic [7:0] last;
		last = 8'hCC - 8'(17 * (n - 1));
		b = {8'h21, 8'h00, 8'h00, 8'h13, 8'hA2, 8'h00, 8'h12, 8'h34, 8'h56, 8'h78};
		b = {b, 8'hDD, 8'hDD, 8'h00, hops};
		for (int i = 0; i < 2 * n; i++) begin
			b.push_back(8'hCC - 8'(17 * (i / 2)));
		end
		adds = 0;
		drops = 0;
		host.send(b, bad);
		repeat (8) @(negedge clk);
		chk("added", 64'(adds), 64'(ok));
		chk("dropped", 64'(drops), 64'(!ok));
		chk("reply", 64'(host.rq.size()), 64'h0);
		if (ok) begin
			rt_rd_slot = 3'(slot);
			slot++;
			repeat (2) @(negedge clk);
			chk("rd_valid", 64'(rt_rd_valid), 64'h1);
			chk("rd_hops", 64'(rt_rd_hops), 64'(n));
			chk("dest64", rt_rd_dest64, 64'h0013_A200_1234_5678);
			chk("dest16", 64'(rt_rd_dest16), 64'hDDDD);
			chk("hop1", 64'(rt_rd_hop_list[479 -: 16]), 64'hCCCC);
			chk("hopn", 64'(rt_rd_hop_list[479 - 16 * (n - 1) -: 16]), 64'({last, last}));
		end
	endtask
	task automatic lcmd(input logic [7:0] ty, input logic [7:0] id, input logic [15:0] cmd, bit q);
		logic [7:0] b[$];
		b = {ty, id, cmd[15:8], cmd[7:0]};
		if (!q) begin
			b.push_back(8'h45);
		end
		host.send(b, 8'h00);
		for (int i = 0; i < 10 && lcmd_valid !== 1'b1; i++) begin
			@(negedge clk);
		end
		chk("lcmd_valid", 64'(lcmd_valid), 64'h1);
		chk("lcmd_id", 64'(lcmd_id), 64'(id));
		chk("lcmd_cmd", 64'(lcmd_cmd), 64'(cmd));
		chk("lcmd_query", 64'(lcmd_query), 64'(q));
	endtask
	task automatic give(input logic [1:0] st, input int n, input logic [127:0] d, input bit more);
		int i;
		i = 0;
		res_valid = 1'b1;
		res_status = st;
		res_data_len = 5'(n);
		res_data = d;
		res_more = more;
		#1;
		while (res_ready !== 1'b1 && i < 60) begin
			@(negedge clk);
			#1;
			i++;
		end
		chk("res_ready", 64'(res_ready), 64'h1);
		@(negedge clk);
		res_valid = 1'b0;
		@(negedge clk);
	endtask
	task automatic expect_resp(input logic [7:0] id, logic [15:0] cmd, logic [1:0] st, int n,
		logic [127:0] d);
		logic [7:0] e[$];
		logic [7:0] sum;
		e = {8'h7E, 8'h00, 8'(5 + n), 8'h88, id, cmd[15:8], cmd[7:0], 8'(st)};
		for (int i = 0; i < n; i++) begin
			e.push_back(d[127 - 8 * i -: 8]);
		end
		sum = 8'h00;
		for (int i = 3; i < e.size(); i++) begin
			sum += e[i];
		end
		e.push_back(8'hFF - sum);
		for (int i = 0; i < 80 && host.rq.size() < e.size(); i++) begin
			@(negedge clk);
		end
		chk("resp_len", 64'(host.rq.size() >= e.size()), 64'h1);
		foreach (e[i]) begin
			chk("resp", 64'(host.rq.size() > 0 ? host.rq.pop_front() : 8'hXX), 64'(e[i]));
		end
	endtask
	task automatic t_route_good();
		route(3, 8'h03, 8'h00, 1'b1);
		route(30, 8'h1E, 8'h00, 1'b1);
	endtask
	task automatic t_route_bad();
		route(0, 8'h00, 8'h00, 1'b0);
		route(31, 8'h1F, 8'h00, 1'b0);
		route(3, 8'h03, 8'h01, 1'b0);
		route(3, 8'h02, 8'h00, 1'b0);
	endtask
	task automatic t_set();
		for (int s = 0; s < 4; s++) begin
			lcmd(8'h08, 8'hA1 + 8'(s), 16'h4E49, 1'b0);
			give(2'(s), 0, 128'h0, 1'b0);
			expect_resp(8'hA1 + 8'(s), 16'h4E49, 2'(s), 0, 128'h0);
		end
	endtask
	task automatic t_query();
		lcmd(8'h09, 8'h17, 16'h5450, 1'b1);
		give(2'h0, 2, {16'hFFFE, 112'h0}, 1'b0);
		expect_resp(8'h17, 16'h5450, 2'h0, 2, {16'hFFFE, 112'h0});
	endtask
	task automatic t_zero_id();
		lcmd(8'h08, 8'h00, 16'h4E49, 1'b0);
		res_valid = 1'b1;
		repeat (30) @(negedge clk);
		res_valid = 1'b0;
		repeat (5) @(negedge clk);
		chk("zero_id_reply", 64'(host.rq.size()), 64'h0);
	endtask
	task automatic t_multi();
		lcmd(8'h08, 8'h5A, srf_pkg::NODE_DISC_CMD, 1'b1);
		give(2'h0, 2, {16'h1234, 112'h0}, 1'b1);
		give(2'h0, 2, {16'h5678, 112'h0}, 1'b0);
		expect_resp(8'h5A, srf_pkg::NODE_DISC_CMD, 2'h0, 2, {16'h1234, 112'h0});
		expect_resp(8'h5A, srf_pkg::NODE_DISC_CMD, 2'h0, 2, {16'h5678, 112'h0});
	endtask
	initial begin
		repeat (6) @(negedge clk);
		srst = 1'b0;
		t_route_good();
		t_route_bad();
		t_set();
		t_query();
		t_zero_id();
		t_multi();
		end_sim();
	end
	// the tests need well under a thousand cycles; twenty thousand means a hang
	initial begin
		#2000000;
		bad_count++;
		end_sim();
	end
endmodule
